// ### indirect_host_port.sv
// indirect 8-bit host port onto a 12-bit by 32-bit register space
`include "host_port_consts.svh"

module indirect_host_port
  import host_port_pkg::*;
(
  input  wire logic        clock_i,          // 125 MHz core clock
  input  wire logic        reset_n_i,        // async reset, low
  input  wire logic        data_strobe_style_i, // static style pin
  input  wire logic        chip_select_n_i,  // port select, low
  input  wire logic        data_strobe_n_i,  // read or data strobe
  input  wire logic        write_n_rw_i,     // write strobe or dir
  input  wire logic [2:0]  ext_addr_i,       // external register
  input  wire logic [7:0]  data_i,           // host data in
  output logic      [7:0]  data_o,           // host data out
  output logic             data_oe_o,        // drive data bus
  output logic             access_ack_n_o,   // open-drain level
  output logic             access_ack_oe_o,  // pull line low
  output logic      [11:0] int_addr_o,       // internal address
  output logic      [31:0] int_wdata_o,      // internal write word
  output logic             int_wr_o,         // internal write
  output logic             int_rd_o,         // internal read
  input  wire logic [31:0] int_rdata_i,      // internal read word
  output logic      [3:0]  program_enable_o, // memory programming
  output logic      [3:0]  channel_awake_o,  // channel active
  output logic      [3:0]  sync_beam_o,      // beam sync pulse
  output logic      [3:0]  sync_hop_o,       // hop sync pulse
  output logic      [3:0]  sync_start_o      // start sync pulse
);

  // released reset and its first stage
  logic        rst_meta;
  logic        rst_n;
  // access sequencing
  port_state_t state;
  logic [1:0]  cycle_cnt;     // cycles spent inside
  logic        strobe_q;      // strobe seen last cycle
  logic        strobe_on;     // host strobe active now
  logic        start;         // new access this cycle
  logic        done;          // internal access ends
  host_req_t   req;           // access as on the pins
  host_req_t   req_q;         // access being served
  // register file
  logic [11:0] internal_address;
  logic [1:0]  autoinc;       // {write, read} increment
  logic [31:0] data_word;
  logic [7:0]  power_program;

  // register 0 is the only one with an internal cycle
  function automatic logic launches(input logic [2:0] off);
    return off == `OFF_DATA0;
  endfunction

  // readback value of a register without internal cycle
  function automatic logic [7:0] read_byte(input logic [2:0] off);
    case (off)
      `OFF_DATA1:   read_byte = data_word[15:8];
      `OFF_DATA2:   read_byte = data_word[23:16];
      `OFF_DATA3:   read_byte = data_word[31:24];
      `OFF_POWER:   read_byte = power_program;
      `OFF_ADDR_LO: read_byte = internal_address[7:0];
      `OFF_ADDR_HI: read_byte = {autoinc, 2'b00,
                                 internal_address[11:8]};
      default:      read_byte = `RST_BYTE; // sync is write only
    endcase
  endfunction

  // reset release through two stages
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // strobe decode for the two bus styles
  always_comb
  begin
    if (data_strobe_style_i)
    begin
      strobe_on = !chip_select_n_i && !data_strobe_n_i;
      req.rd    = write_n_rw_i;
    end
    else
    begin
      strobe_on = !chip_select_n_i &&
                  (!data_strobe_n_i || !write_n_rw_i);
      req.rd    = !data_strobe_n_i;
    end
    req.offset = ext_addr_i;
    req.wdata  = data_i;
  end

  // new access only from idle; chip select may stay low
  assign start = strobe_on && !strobe_q && state == ST_IDLE;
  assign done  = state == ST_INTERNAL &&
                 cycle_cnt == `INT_ACCESS_CYCLES - 2'h1;

  // strobe history and the captured access
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_q <= 1'b0;
      req_q    <= '0;
    end
    else
    begin
      strobe_q <= strobe_on;
      if (start)
        req_q <= req;
    end
  end

  // sequencer: idle, internal cycle, wait for strobe release
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= ST_IDLE;
      cycle_cnt <= 2'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          cycle_cnt <= 2'h0;
          if (start && launches(req.offset))
            state <= ST_INTERNAL;
          else if (start)
            state <= ST_HOLD;
        end
        ST_INTERNAL:
        begin
          cycle_cnt <= cycle_cnt + 2'h1;
          if (done)
            state <= ST_HOLD;
        end
        ST_HOLD:
        begin
          if (!strobe_on)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // internal strobes last the whole internal cycle
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_wr_o <= 1'b0;
      int_rd_o <= 1'b0;
    end
    else if (start && launches(req.offset))
    begin
      int_wr_o <= !req.rd;
      int_rd_o <= req.rd;
    end
    else if (done)
    begin
      int_wr_o <= 1'b0;
      int_rd_o <= 1'b0;
    end
  end

  // data bytes: host writes, or filled by an internal read
  for (genvar k = 0; k < 4; k++)
  begin : g_data_byte
    always_ff @(posedge clock_i or negedge rst_n)
    begin
      if (!rst_n)
        data_word[8*k +: 8] <= `RST_BYTE;
      else if (start && !req.rd && req.offset == 3'(k))
        data_word[8*k +: 8] <= req.wdata;
      else if (done && req_q.rd)
        data_word[8*k +: 8] <= int_rdata_i[8*k +: 8];
    end
  end
  assign int_wdata_o = data_word;

  // address registers and auto increment
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      internal_address <= `RST_ADDR;
      autoinc          <= 2'b00;
    end
    else if (start && !req.rd && req.offset == `OFF_ADDR_HI)
    begin
      internal_address[11:8] <= req.wdata[3:0];
      autoinc <= {req.wdata[`HI_WRINC_BIT],
                  req.wdata[`HI_RDINC_BIT]};
    end
    else if (start && !req.rd && req.offset == `OFF_ADDR_LO)
      internal_address[7:0] <= req.wdata;
    else if (done && ((req_q.rd && autoinc[0]) ||
                      (!req_q.rd && autoinc[1])))
      internal_address <= internal_address + 12'h001;
  end
  assign int_addr_o = internal_address;

  // power register; start syncs put channels to sleep
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      power_program <= `RST_BYTE;
    else if (start && !req.rd && req.offset == `OFF_POWER)
      power_program <= req.wdata;
    else
      power_program[3:0] <= power_program[3:0] & ~sync_start_o;
  end
  assign program_enable_o = power_program[7:4];
  assign channel_awake_o  = power_program[3:0];

  // sync commands: one-cycle pulse per selected channel
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_beam_o  <= `RST_NIBBLE;
      sync_hop_o   <= `RST_NIBBLE;
      sync_start_o <= `RST_NIBBLE;
    end
    else if (start && !req.rd && req.offset == `OFF_SYNC)
    begin
      sync_beam_o  <= req.wdata[3:0] &
                      {4{req.wdata[`SYNC_BEAM_BIT]}};
      sync_hop_o   <= req.wdata[3:0] &
                      {4{req.wdata[`SYNC_HOP_BIT]}};
      sync_start_o <= req.wdata[3:0] &
                      {4{req.wdata[`SYNC_START_BIT]}};
    end
    else
    begin
      sync_beam_o  <= `RST_NIBBLE;
      sync_hop_o   <= `RST_NIBBLE;
      sync_start_o <= `RST_NIBBLE;
    end
  end

  // read data: byte 0 waits for the internal word
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_o    <= `RST_BYTE;
      data_oe_o <= 1'b0;
    end
    else
    begin
      if (start && req.rd && !launches(req.offset))
        data_o <= read_byte(req.offset);
      else if (done && req_q.rd)
        data_o <= int_rdata_i[7:0];
      if (start && req.rd)
        data_oe_o <= 1'b1;
      else if (state == ST_HOLD && !strobe_on)
        data_oe_o <= 1'b0;
    end
  end

  // ready/ack: only ever pulls low, never drives high
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      access_ack_n_o  <= 1'b0;
      access_ack_oe_o <= 1'b0;
    end
    else if (start)
      // split: busy at once; strobe: ack if no wait
      access_ack_oe_o <= !data_strobe_style_i ||
                         !launches(req.offset);
    else if (done)
      access_ack_oe_o <= data_strobe_style_i;
    else if (state == ST_HOLD &&
             (!data_strobe_style_i || !strobe_on))
      access_ack_oe_o <= 1'b0;
  end

  // checks next to the logic
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);
  sequence int_busy_two;
    (int_rd_o || int_wr_o) ##1 (int_rd_o || int_wr_o)
      ##1 !(int_rd_o || int_wr_o);
  endsequence
  sequence wr_data0;
    start && !req.rd && launches(req.offset);
  endsequence
  a_int_two_cycles: assert property (
    $rose(int_rd_o || int_wr_o) |-> int_busy_two)
    else $error("internal access not two cycles");
  a_wr_launch: assert property (
    wr_data0 |=> int_wr_o && !int_rd_o &&
      int_wdata_o[7:0] == $past(data_i))
    else $error("byte 0 write did not launch");
  a_rd_launch: assert property (
    start && req.rd && launches(req.offset)
      |=> int_rd_o ##2 !int_rd_o)
    else $error("byte 0 read did not launch");
  a_rd_capture: assert property (
    $fell(int_rd_o) |->
      data_o == $past(int_rdata_i[7:0]) &&
      data_word == $past(int_rdata_i))
    else $error("read word not captured");
  a_autoinc_read: assert property (
    done && req_q.rd && autoinc[0] |=>
      internal_address == $past(internal_address) + 12'h001)
    else $error("read auto increment missed");
  a_no_inc_off: assert property (
    done && autoinc == 2'b00 |=> $stable(internal_address))
    else $error("address moved without increment");
  a_sync_start: assert property (
    start && !req.rd && req.offset == `OFF_SYNC |=>
      sync_start_o == ($past(data_i[3:0]) &
                       {4{$past(data_i[4])}}) ##1
      sync_start_o == `RST_NIBBLE)
    else $error("start sync pulse wrong");
  a_sleep_clear: assert property (
    |sync_start_o |=> (channel_awake_o & $past(sync_start_o)) == 4'h0)
    else $error("start sync left channel awake");
  a_split_ready: assert property (
    !data_strobe_style_i && start && launches(req.offset)
      |=> access_ack_oe_o [*2] ##1 !access_ack_oe_o)
    else $error("ready not held for internal cycle");
  a_ds_ack_release: assert property (
    data_strobe_style_i && state == ST_HOLD && !strobe_on
      |=> !access_ack_oe_o)
    else $error("ack not released after strobe");

endmodule // indirect_host_port

// ### host_port_consts.svh
// offsets, bit positions, reset values and counts of the host port
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
`define OFF_DATA0 3'h0
`define OFF_DATA1 3'h1
`define OFF_DATA2 3'h2
`define OFF_DATA3 3'h3
`define OFF_POWER 3'h4
`define OFF_SYNC 3'h5
`define OFF_ADDR_LO 3'h6
`define OFF_ADDR_HI 3'h7
`define HI_WRINC_BIT 7
`define HI_RDINC_BIT 6
`define SYNC_BEAM_BIT 6
`define SYNC_HOP_BIT 5
`define SYNC_START_BIT 4
`define INT_ACCESS_CYCLES 2'h2
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define RST_WORD 32'h0000_0000
`define RST_ADDR 12'h000
`endif

// ### host_port_pkg.sv
// types shared by the indirect host port
package host_port_pkg;
  // access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INTERNAL,
    ST_HOLD
  } port_state_t;
  // one host access as caught at the strobe edge
  typedef struct packed {
    logic       rd;
    logic [2:0] offset;
    logic [7:0] wdata;
  } host_req_t;
endpackage

// ### int_reg_space_model.sv
// internal register space seen behind the host port, sixteen words deep
module int_reg_space_model
(
  input  wire logic        clock_i,     // core clock
  input  wire logic [11:0] int_addr_i,  // internal address
  input  wire logic [31:0] int_wdata_i, // word to store
  input  wire logic        int_wr_i,    // write strobe, two cycles
  input  wire logic        int_rd_i,    // read strobe, two cycles
  output logic      [31:0] int_rdata_o  // word returned
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [16];                // only low address bits decode
  // store the word while the write strobe stands
  always_ff @(posedge clock_i)
  begin
    if (int_wr_i)
      mem[int_addr_i[3:0]] <= int_wdata_i;
  end
  // outside a read the bus shows the inverse, never a stale copy
  always_comb
  begin
    if (int_rd_i)
      int_rdata_o = mem[int_addr_i[3:0]];
    else
      int_rdata_o = ~mem[int_addr_i[3:0]];
  end
endmodule // int_reg_space_model

// ### tb_indirect_host_port.sv
// self-checking bench of the indirect host port in both strobe styles
module tb_indirect_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, reset_n, style, cs_n, ds_n, wr_n;
  logic [2:0]  ea;
  logic [7:0]  din, dout;
  logic        doe, ack_n, ack_oe, iwr, ird;
  logic [11:0] iaddr;
  logic [31:0] iwdata, irdata;
  logic [3:0]  prog, awake, beam, hop, start;
  logic [3:0]  beam_seen, hop_seen, start_seen; // sync pulses caught
  int          nwr, nrd;                        // internal strobe cycles
  int          err_count, n_compared;
  indirect_host_port dut (.clock_i(clock), .reset_n_i(reset_n),
    .data_strobe_style_i(style), .chip_select_n_i(cs_n),
    .data_strobe_n_i(ds_n), .write_n_rw_i(wr_n), .ext_addr_i(ea),
    .data_i(din), .data_o(dout), .data_oe_o(doe), .access_ack_n_o(ack_n),
    .access_ack_oe_o(ack_oe), .int_addr_o(iaddr), .int_wdata_o(iwdata),
    .int_wr_o(iwr), .int_rd_o(ird), .int_rdata_i(irdata),
    .program_enable_o(prog), .channel_awake_o(awake), .sync_beam_o(beam),
    .sync_hop_o(hop), .sync_start_o(start));
  int_reg_space_model far (.clock_i(clock), .int_addr_i(iaddr),
    .int_wdata_i(iwdata), .int_wr_i(iwr), .int_rd_i(ird),
    .int_rdata_o(irdata));
  // free running core clock, 8 ns
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // strobe cycle counters and sync pulse catchers
  always @(posedge clock)
  begin
    if (iwr === 1'b1) nwr++;
    if (ird === 1'b1) nrd++;
    beam_seen  |= beam;
    hop_seen   |= hop;
    start_seen |= start;
  end
  // one comparison, counted; mismatches reported at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one host access; chip select stays low between accesses
  task automatic acc(input logic rd, input logic [2:0] off,
                     input logic [7:0] wd, output logic [7:0] rdv);
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    cs_n = 1'b0;
    ea = off;
    din = wd;
    if (style) wr_n = rd; // direction level in strobe style
    else if (!rd) wr_n = 1'b0;
    if (style || rd) ds_n = 1'b0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
      if (ack_oe === 1'b1) seen = 1'b1;
    end
    while (n < 20 && !(style ? ack_oe === 1'b1 : (seen && ack_oe === 1'b0)));
    check(n < 20, 1);
    check(ack_n, 1'b0);
    if (rd) check(doe, 1'b1);
    rdv = dout;
    ds_n = 1'b1;
    wr_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check(ack_oe, 1'b0);
  endtask
  task automatic wr(input logic [2:0] off, input logic [7:0] d);
    logic [7:0] x;
    acc(1'b0, off, d, x);
  endtask
  task automatic rd(input logic [2:0] off, input logic [7:0] exp);
    logic [7:0] x;
    acc(1'b1, off, 8'h00, x);
    check(x, exp);
  endtask
  // watchdog: each style pass takes well under 2000 cycles
  initial
  begin
    #100000;
    err_count++;
    finish_test();
  end
  // main sequence, once per strobe style
  initial
  begin
    {cs_n, ds_n, wr_n} = 3'b111;
    {reset_n, style, ea, din} = '0;
    {err_count, n_compared, nwr, nrd} = '0;
    {beam_seen, hop_seen, start_seen} = '0;
    for (int s = 0; s < 2; s++)
    begin
      reset_n = 1'b0;
      style = s[0];
      repeat (3) @(posedge clock);
      #1;
      reset_n = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      wr(3'h7, 8'hB1);
      wr(3'h6, 8'h05);
      rd(3'h7, 8'h81);
      rd(3'h6, 8'h05);
      wr(3'h3, 8'hA1);
      wr(3'h2, 8'hB2);
      wr(3'h1, 8'hC3);
      nwr = 0;
      wr(3'h0, 8'hD4);
      check(nwr, 2);
      check(iwdata, 32'hA1B2_C3D4);
      check(iaddr, 12'h106);
      rd(3'h6, 8'h06);
      wr(3'h7, 8'h41);
      wr(3'h6, 8'h05);
      wr(3'h1, 8'h77);
      nrd = 0;
      rd(3'h0, 8'hD4);
      check(nrd, 2);
      rd(3'h3, 8'hA1);
      rd(3'h1, 8'hC3);
      rd(3'h2, 8'hB2);
      rd(3'h6, 8'h06);
      wr(3'h7, 8'hCF);
      wr(3'h6, 8'hFF);
      wr(3'h0, 8'h11);
      rd(3'h7, 8'hC0);
      rd(3'h6, 8'h00);
      // no increment bits: address must stay put after the access
      wr(3'h7, 8'h00);
      wr(3'h6, 8'h05);
      rd(3'h7, 8'h00);
      wr(3'h1, 8'h9A);
      wr(3'h0, 8'hBC);
      check(iwdata, 32'hA1B2_9ABC);
      rd(3'h0, 8'hBC);
      rd(3'h1, 8'h9A);
      rd(3'h6, 8'h05);
      check(iaddr, 12'h005);
      wr(3'h4, 8'hF5);
      check({prog, awake}, 8'hF5);
      rd(3'h4, 8'hF5);
      {beam_seen, hop_seen, start_seen} = '0;
      wr(3'h5, 8'h14);
      check({beam_seen, hop_seen, start_seen}, 12'h004);
      check(awake, 4'h1);
      {beam_seen, hop_seen, start_seen} = '0;
      wr(3'h5, 8'h6F);
      check({beam_seen, hop_seen, start_seen}, 12'hFF0);
      rd(3'h5, 8'h00);
      {beam_seen, hop_seen, start_seen} = '0;
      wr(3'h5, 8'h00);
      check({beam_seen, hop_seen, start_seen}, 12'h000);
      check(awake, 4'h1);
      cs_n = 1'b1;
    end
    finish_test();
  end
endmodule // tb_indirect_host_port
